// file: logic/sdram_cmd_consts.svh
// Constants for the synchronous DRAM command decoder.
// Assumes inclusion by the package and the decoder files.
`ifndef SDRAM_CMD_CONSTS_SVH
`define SDRAM_CMD_CONSTS_SVH
`define DATA_W 16
`define BANK_W 2
`define ADDR_W 12
`define NUM_BANKS 4
`define PRECHARGE_BIT 10
`define BURST_W 4
`define MASK_LATENCY 2
`define DEFAULT_BURST 4'h4
`endif

// file: logic/sdram_cmd_pkg.sv
// Types shared by the synchronous DRAM command decoder.
// Assumes the constants header sits in the include path.
`include "sdram_cmd_consts.svh"
package sdram_cmd_pkg;
	typedef enum logic [3:0] {
		cmd_deselect,
		cmd_nop,
		cmd_open_row,
		cmd_close_bank,
		cmd_close_all,
		cmd_read,
		cmd_write,
		cmd_mode_set,
		cmd_refresh,
		cmd_self_refresh,
		cmd_burst_stop
	} cmd_t;
	typedef enum logic [1:0] {
		pwr_normal,
		pwr_suspend,
		pwr_down,
		pwr_self_refresh
	} pwr_state_t;
endpackage

// file: logic/sdram_command_decoder.sv
// Command decoder and power-state control for a 16-bit synchronous DRAM.
// Assumes pins are synchronised here; memory array lives outside.
// Summary of operation
// [R1] Every command is captured on the rising clock edge only.
// [R2] Data pins carry write and read words, synchronous, both directions.
// [R3] Low mask stores write data and drives reads; high blocks both.
// [R4] Clock gate level from the previous cycle is kept for decoding.
// [R5] Clock gate level of the command cycle is the current level.
// [R6] Activate needs an idle bank; read and write need an active bank.
// [R7] Burst stop accepted in any burst; select low, column/row high, we low.
// [R8] Active bank and clock gate falling with a command other than deselect or no-op enters clock suspend.
// [R9] Clock gate falling with deselect or no-op enters power down.
// [R10] Power-down entry during a burst gives clock suspend instead.
// [R11] Clock gate rising leaves clock suspend; other inputs ignored.
// [R12] Controller leaves power down by raising gate with deselect or no-op.
// [R13] Select high masks every command.
// [R14] Row low, column high: we high activates, we low precharges.
// [R15] Precharge flag bit high closes all banks, ignoring bank select.
// [R16] Byte masks gate read drivers three cycles later.
// [R17] Read and write codes; precharge flag bit adds auto precharge.
// [R18] All strobes low: we low mode set; we high refresh or self refresh.
// [R19] Gate rising with deselect or no-op leaves self refresh.
`timescale 1ns/1ps
`include "sdram_cmd_consts.svh"
module sdram_command_decoder
	import sdram_cmd_pkg::*;
#(
	parameter int DATA_W = `DATA_W,
	parameter int NUM_BANKS = `NUM_BANKS
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic select_n, // Chip select, active low
	input wire logic row_strobe_n, // Row strobe, active low
	input wire logic col_strobe_n, // Column strobe, active low
	input wire logic write_strobe_n, // Write strobe, active low
	input wire logic [`BANK_W-1:0] bank_select, // Bank address
	input wire logic [`ADDR_W-1:0] addr, // Address
	input wire logic [1:0] lower_upper_byte_mask, // Byte masks
	input wire logic clock_gate, // Clock gate pin
	input wire logic [DATA_W-1:0] data_pins_in, // Data pin input
	output logic [DATA_W-1:0] data_pins_out, // Data pin output
	output logic [1:0] data_pins_oe, // Per-byte drive enable
	input wire logic [DATA_W-1:0] rd_word, // Read word from array
	output logic [DATA_W-1:0] wr_word, // Write word to array
	output logic [1:0] wr_byte_en, // Write byte enables
	output logic wr_strobe, // Write word valid
	output logic rd_strobe, // Read word wanted
	output logic [`ADDR_W-1:0] mode_word, // Last mode set value
	output logic refresh_pulse, // Refresh requested
	output logic [NUM_BANKS-1:0] bank_active, // Open banks
	output pwr_state_t pwr_state, // Power state
	output logic cmd_error // Command illegal for bank state
);
	logic s1_sel, s1_ras, s1_cas, s1_we, s1_cke;
	logic sel_n, ras_n, cas_n, we_n;
	logic [`BANK_W-1:0] s1_ba, ba;
	logic [`ADDR_W-1:0] s1_a, a;
	logic [1:0] s1_m, m;
	logic [DATA_W-1:0] s1_d, d;
	logic clock_gate_now, clock_gate_prev;
	cmd_t cmd;
	logic [`BURST_W-1:0] burst_left;
	logic burst_read, burst_write;
	logic in_burst;
	logic [1:0] rd_mask;
	logic rd_pipe;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Two-flop synchronisers on every pin
	always_ff @(posedge ref_clk) begin // [R1]
		s1_sel <= select_n;
		s1_ras <= row_strobe_n;
		s1_cas <= col_strobe_n;
		s1_we <= write_strobe_n;
		s1_cke <= clock_gate;
		s1_ba <= bank_select;
		s1_a <= addr;
		s1_m <= lower_upper_byte_mask;
		s1_d <= data_pins_in;
		sel_n <= s1_sel;
		ras_n <= s1_ras;
		cas_n <= s1_cas;
		we_n <= s1_we;
		clock_gate_now <= s1_cke; // [R5]
		ba <= s1_ba;
		a <= s1_a;
		m <= s1_m;
		d <= s1_d;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) clock_gate_prev <= 1'b1;
		else clock_gate_prev <= clock_gate_now; // [R4]
	end

	function automatic cmd_t decode(input logic s, input logic r,
		input logic c, input logic w, input logic pa, input logic ck);
		if (s) return cmd_deselect; // [R13]
		case ({r, c, w})
			3'h7: return cmd_nop;
			3'h6: return cmd_burst_stop; // [R7]
			3'h3: return cmd_open_row; // [R14]
			3'h2: return pa ? cmd_close_all : cmd_close_bank; // [R15]
			3'h5: return cmd_read; // [R17]
			3'h4: return cmd_write; // [R17]
			3'h0: return cmd_mode_set; // [R18]
			3'h1: return ck ? cmd_refresh : cmd_self_refresh; // [R18]
			default: return cmd_nop;
		endcase
	endfunction

	assign cmd = decode(sel_n, ras_n, cas_n, we_n, a[`PRECHARGE_BIT],
		clock_gate_now);
	assign in_burst = burst_left != '0;
	logic entry_now, exit_now, idle_cmd, any_active;
	assign entry_now = clock_gate_prev && !clock_gate_now;
	assign exit_now = !clock_gate_prev && clock_gate_now;
	assign idle_cmd = (cmd == cmd_deselect) || (cmd == cmd_nop);
	assign any_active = |bank_active;
	logic normal_go;
	assign normal_go = (pwr_state == pwr_normal) && clock_gate_prev;

	// Power state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwr_state <= pwr_normal;
		end else begin
			case (pwr_state)
				pwr_normal: begin
					if (entry_now) begin
						if (in_burst)
							pwr_state <= pwr_suspend; // [R10]
						else if (cmd == cmd_self_refresh && !any_active)
							pwr_state <= pwr_self_refresh; // [R18]
						else if (idle_cmd)
							pwr_state <= pwr_down; // [R9]
						else if (any_active)
							pwr_state <= pwr_suspend; // [R8]
					end
				end
				pwr_suspend: begin
					if (exit_now) pwr_state <= pwr_normal; // [R11]
				end
				pwr_down: begin
					if (exit_now && idle_cmd)
						pwr_state <= pwr_normal; // [R12]
				end
				default: begin
					if (exit_now && idle_cmd)
						pwr_state <= pwr_normal; // [R19]
				end
			endcase
		end
	end

	// Bank state, checked per command
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bank_active <= '0;
			cmd_error <= 1'b0;
		end else begin
			cmd_error <= 1'b0;
			if (normal_go) begin
				case (cmd)
					cmd_open_row: begin
						if (bank_active[ba]) cmd_error <= 1'b1; // [R6]
						else bank_active[ba] <= 1'b1;
					end
					cmd_close_bank: bank_active[ba] <= 1'b0;
					cmd_close_all: bank_active <= '0; // [R15]
					cmd_read, cmd_write: begin
						if (!bank_active[ba]) cmd_error <= 1'b1; // [R6]
						else if (a[`PRECHARGE_BIT])
							bank_active[ba] <= 1'b0; // [R17]
					end
					cmd_mode_set, cmd_refresh: begin
						if (any_active) cmd_error <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	logic legal_rw;
	assign legal_rw = normal_go && bank_active[ba];

	// Burst tracking; frozen while suspended
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			burst_left <= '0;
			burst_read <= 1'b0;
			burst_write <= 1'b0;
			mode_word <= '0;
		end else if (pwr_state == pwr_normal) begin
			if (normal_go && cmd == cmd_mode_set && !any_active)
				mode_word <= a;
			if (legal_rw && (cmd == cmd_read || cmd == cmd_write)) begin
				burst_left <= `DEFAULT_BURST - 4'h1;
				burst_read <= cmd == cmd_read;
				burst_write <= cmd == cmd_write;
			end else if (normal_go && (cmd == cmd_burst_stop ||
				cmd == cmd_close_bank || cmd == cmd_close_all)) begin
				burst_left <= '0; // [R7]
				burst_read <= 1'b0;
				burst_write <= 1'b0;
			end else if (in_burst) begin
				burst_left <= burst_left - 4'h1;
			end else begin
				burst_read <= 1'b0;
				burst_write <= 1'b0;
			end
		end
	end

	logic wr_beat, rd_beat, run;
	assign run = (pwr_state == pwr_normal) && clock_gate_now;
	assign wr_beat = run && ((legal_rw && cmd == cmd_write) ||
		(burst_write && in_burst && cmd != cmd_read));
	assign rd_beat = run && ((legal_rw && cmd == cmd_read) ||
		(burst_read && in_burst));

	// Write path: mask blocks the byte
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_word <= '0;
			wr_byte_en <= 2'h0;
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
			rd_pipe <= 1'b0;
		end else begin
			wr_word <= d; // [R2]
			wr_byte_en <= wr_beat ? ~m : 2'h0; // [R3]
			wr_strobe <= wr_beat;
			rd_strobe <= rd_beat;
			rd_pipe <= rd_strobe;
		end
	end

	sdram_mask_pipe #(
		.LATENCY(`MASK_LATENCY)
	) u_mask_pipe (
		.ref_clk(ref_clk),
		.rst(rst),
		.mask_in(m),
		.mask_out(rd_mask)
	);

	// Read drivers, enabled per byte by the delayed mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			data_pins_out <= '0;
			data_pins_oe <= 2'h0;
		end else begin
			data_pins_out <= rd_word; // [R2]
			data_pins_oe <= rd_pipe ? ~rd_mask : 2'h0; // [R3] [R16]
		end
	end
	assign refresh_pulse = normal_go && cmd == cmd_refresh && !any_active;
	sequence gate_fall_s;
		clock_gate_prev && !clock_gate_now;
	endsequence
	property burst_suspend_p;
		(pwr_state == pwr_normal && in_burst) ##0 gate_fall_s
		|=> pwr_state == pwr_suspend;
	endproperty
	burst_suspend_a: assert property (burst_suspend_p) // [R10]
		else $error("Burst gate fall did not suspend");
	suspend_exit_a: assert property ( // [R11]
		pwr_state == pwr_suspend && exit_now |=> pwr_state == pwr_normal)
		else $error("Suspend not left on gate rise");
	down_entry_a: assert property ( // [R9]
		pwr_state == pwr_normal && entry_now && idle_cmd && !in_burst
		|=> pwr_state == pwr_down)
		else $error("Power down not entered");
	open_idle_a: assert property ( // [R6]
		normal_go && cmd == cmd_open_row && !bank_active[ba]
		|=> bank_active[$past(ba)] && !cmd_error)
		else $error("Activate did not open bank");
	close_all_a: assert property ( // [R15]
		normal_go && cmd == cmd_close_all |=> bank_active == '0)
		else $error("Close all left a bank open");
	deselect_hold_a: assert property ( // [R13]
		sel_n && pwr_state == pwr_normal |=> $stable(bank_active))
		else $error("Deselect changed bank state");
	mask_latency_a: assert property ( // [R16]
		rd_beat |-> ##3 data_pins_oe == ~$past(m, 3))
		else $error("Read drivers ignored the delayed mask");
	write_mask_a: assert property ( // [R3]
		wr_beat |=> wr_byte_en == ~$past(m))
		else $error("Write byte enable wrong");
	self_exit_a: assert property ( // [R19]
		pwr_state == pwr_self_refresh && exit_now && idle_cmd
		|=> pwr_state == pwr_normal)
		else $error("Self refresh not left");
endmodule

// file: logic/sdram_mask_pipe.sv
// Two-stage delay of the byte masks for the read output drivers.
// Assumes masks already synchronised to ref_clk.
`timescale 1ns/1ps
`include "sdram_cmd_consts.svh"
module sdram_mask_pipe #(
	parameter int LATENCY = `MASK_LATENCY
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Synchronous reset
	input wire logic [1:0] mask_in, // Mask now
	output logic [1:0] mask_out // Mask LATENCY cycles ago
);
	logic [1:0] stage [LATENCY];
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < LATENCY; i++) stage[i] <= 2'h3;
		end else begin
			stage[0] <= mask_in;
			for (int i = 1; i < LATENCY; i++) stage[i] <= stage[i-1];
		end
	end
	assign mask_out = stage[LATENCY-1];
endmodule

// file: tb/sdram_command_decoder_test.sv
// Self-checking bench for the command decoder.
// Assumes the controller model drives all pins; fixed latencies per note.
`timescale 1ns/1ps
module sdram_command_decoder_test;
	import sdram_cmd_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic select_n, row_strobe_n, col_strobe_n, write_strobe_n, clock_gate;
	logic [1:0] bank_select, lower_upper_byte_mask, data_pins_oe, wr_byte_en;
	logic [11:0] addr, mode_word;
	logic [15:0] data_pins_in, data_pins_out, rd_word, wr_word;
	logic wr_strobe, rd_strobe, refresh_pulse, cmd_error;
	logic [3:0] bank_active;
	pwr_state_t pwr_state;
	logic [1:0] oe_seen, ben_seen;
	logic [15:0] d1, d2, d3, r1;
	int n_fail = 0, tests_run = 0, n_wr = 0, n_rd = 0, n_ref = 0, n_err = 0;
	int s;
	always #12.5 ref_clk = ~ref_clk;
	sdram_ctrl_model u_ctrl (.ref_clk(ref_clk), .select_n(select_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n), .bank_select(bank_select),
		.addr(addr), .lower_upper_byte_mask(lower_upper_byte_mask),
		.clock_gate(clock_gate), .data_pins_in(data_pins_in),
		.rd_word(rd_word));
	sdram_command_decoder u_dut (.ref_clk(ref_clk), .rst(rst),
		.select_n(select_n), .row_strobe_n(row_strobe_n),
		.col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n),
		.bank_select(bank_select), .addr(addr),
		.lower_upper_byte_mask(lower_upper_byte_mask),
		.clock_gate(clock_gate), .data_pins_in(data_pins_in),
		.data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
		.rd_word(rd_word), .wr_word(wr_word), .wr_byte_en(wr_byte_en),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.mode_word(mode_word), .refresh_pulse(refresh_pulse),
		.bank_active(bank_active), .pwr_state(pwr_state),
		.cmd_error(cmd_error));
	// Pulse counters, seen-enable accumulators and data word checks
	always @(posedge ref_clk) begin
		n_wr += int'(wr_strobe === 1'b1);
		n_rd += int'(rd_strobe === 1'b1);
		n_ref += int'(refresh_pulse === 1'b1);
		n_err += int'(cmd_error === 1'b1);
		oe_seen |= data_pins_oe;
		if (wr_strobe === 1'b1) begin
			ben_seen |= wr_byte_en;
			check(wr_word, d3);
		end
		if (!rst && data_pins_oe !== 2'h0) begin
			check(data_pins_out, r1);
		end
		// Pin history: write word lags pins by three edges
		d3 = d2;
		d2 = d1;
		d1 = data_pins_in;
		r1 = rd_word;
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task results;
		$display("mismatches=%0d checks=%0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task t_open;
		u_ctrl.cmd(4'h3, 2'h1, 12'h000, 1'b1);
		idle(5);
		check(16'(bank_active), 16'h0002);
		s = n_err;
		u_ctrl.cmd(4'h3, 2'h1, 12'h000, 1'b1);
		idle(5);
		check(16'(n_err - s), 16'h0001);
		u_ctrl.cmd(4'hb, 2'h2, 12'h000, 1'b1);
		idle(5);
		check(16'(bank_active), 16'h0002);
	endtask
	task t_write;
		u_ctrl.mask(2'h1);
		ben_seen = 2'h0;
		s = n_wr;
		u_ctrl.cmd(4'h4, 2'h1, 12'h000, 1'b1);
		idle(8);
		check(16'(n_wr - s), 16'h0004);
		check(16'(ben_seen), 16'h0002);
		s = n_wr;
		u_ctrl.cmd(4'h4, 2'h1, 12'h000, 1'b1);
		u_ctrl.cmd(4'h6, 2'h0, 12'h000, 1'b1);
		idle(8);
		check(16'(n_wr - s), 16'h0003);
	endtask
	task t_read;
		u_ctrl.mask(2'h2);
		idle(3);
		oe_seen = 2'h0;
		s = n_rd;
		u_ctrl.cmd(4'h5, 2'h1, 12'h000, 1'b1);
		idle(10);
		check(16'(n_rd - s), 16'h0004);
		check(16'(oe_seen), 16'h0001);
		u_ctrl.cmd(4'h5, 2'h1, 12'h000, 1'b1);
		u_ctrl.cmd(4'h7, 2'h0, 12'h000, 1'b0);
		idle(4);
		check(16'(pwr_state), 16'(pwr_suspend));
		u_ctrl.cmd(4'h3, 2'h0, 12'h000, 1'b1);
		idle(5);
		check(16'(pwr_state), 16'(pwr_normal));
		check(16'(bank_active), 16'h0002);
		u_ctrl.cmd(4'h6, 2'h0, 12'h000, 1'b0);
		idle(5);
		check(16'(pwr_state), 16'(pwr_suspend));
		u_ctrl.cmd(4'h7, 2'h0, 12'h000, 1'b1);
		idle(5);
		check(16'(pwr_state), 16'(pwr_normal));
	endtask
	task t_close;
		u_ctrl.cmd(4'h3, 2'h0, 12'h000, 1'b1);
		u_ctrl.cmd(4'h3, 2'h2, 12'h000, 1'b1);
		u_ctrl.cmd(4'h2, 2'h2, 12'h000, 1'b1);
		idle(5);
		check(16'(bank_active), 16'h0003);
		u_ctrl.cmd(4'h2, 2'h2, 12'h400, 1'b1);
		idle(5);
		check(16'(bank_active), 16'h0000);
	endtask
	task t_modes;
		u_ctrl.cmd(4'h0, 2'h0, 12'h2a5, 1'b1);
		idle(5);
		check(16'(mode_word), 16'h02a5);
		s = n_ref;
		u_ctrl.cmd(4'h1, 2'h0, 12'h000, 1'b1);
		idle(5);
		check(16'(n_ref - s), 16'h0001);
		u_ctrl.cmd(4'h7, 2'h0, 12'h000, 1'b0);
		idle(5);
		check(16'(pwr_state), 16'(pwr_down));
		u_ctrl.cmd(4'h7, 2'h0, 12'h000, 1'b1);
		idle(5);
		check(16'(pwr_state), 16'(pwr_normal));
		u_ctrl.cmd(4'h1, 2'h0, 12'h000, 1'b0);
		idle(5);
		check(16'(pwr_state), 16'(pwr_self_refresh));
		u_ctrl.cmd(4'hf, 2'h0, 12'h000, 1'b1);
		idle(5);
		check(16'(pwr_state), 16'(pwr_normal));
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		idle(3);
		t_open;
		t_write;
		t_read;
		t_close;
		t_modes;
		results;
	end
	// Hang guard
	initial begin
		#1ms;
		n_fail++;
		results;
	end
endmodule

// file: tb/sdram_ctrl_model.sv
// Behavioural memory controller driving the decoder's command pins.
// Assumes one clock; every pin changes only just after a rising edge.
`timescale 1ns/1ps
module sdram_ctrl_model (
	input wire logic ref_clk, // Clock
	output logic select_n, // Chip select
	output logic row_strobe_n, // Row strobe
	output logic col_strobe_n, // Column strobe
	output logic write_strobe_n, // Write strobe
	output logic [1:0] bank_select, // Bank address
	output logic [11:0] addr, // Address
	output logic [1:0] lower_upper_byte_mask, // Byte masks
	output logic clock_gate, // Clock gate
	output logic [15:0] data_pins_in, // Write data
	output logic [15:0] rd_word // Array data
);
	initial begin
		{select_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'hf;
		bank_select = 2'h0;
		addr = 12'h000;
		lower_upper_byte_mask = 2'h0;
		clock_gate = 1'b1;
		data_pins_in = 16'h1234;
		rd_word = 16'h5aa5;
	end
	// Data changes every cycle; write data never repeats, array data alternates between two values
	always @(posedge ref_clk) begin
		data_pins_in <= data_pins_in + 16'h1111;
		rd_word <= ~rd_word + 16'h0101;
	end
	// One command cycle, then no-operation; gate level changes with the command code
	task cmd(input logic [3:0] code, input logic [1:0] ba,
		input logic [11:0] a, input logic g);
		@(posedge ref_clk);
		{select_n, row_strobe_n, col_strobe_n, write_strobe_n} <= code;
		bank_select <= ba;
		addr <= a;
		clock_gate <= g;
		@(posedge ref_clk);
		{select_n, row_strobe_n, col_strobe_n, write_strobe_n} <= 4'h7;
	endtask
	task mask(input logic [1:0] m);
		@(posedge ref_clk);
		lower_upper_byte_mask <= m;
	endtask
endmodule
